// File: verilog/cfsu_pkg.sv
// Purpose: Shared constants and carriers for the controller fault status unit
// Assumes: 32-bit classic Wishbone register access, 10 MHz clock
// Notes: Fault bit positions match the general fault word layout
package cfsu_pkg;

   // Clock and scan watchdog timing
   localparam int CLK_HZ = 10_000_000;
   localparam int WDT_TIME_MS = 200;
   localparam int WDT_CYCLES = (WDT_TIME_MS * (CLK_HZ / 1000));

   // Register byte offsets
   localparam logic [3:0] OFS_GFW = 4'h0;
   localparam logic [3:0] OFS_ECW = 4'h4;
   localparam logic [3:0] OFS_CTRL = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hC;

   // General fault word bit positions
   localparam int BIT_POWER = 0;
   localparam int BIT_WDT = 1;
   localparam int BIT_LINK = 2;
   localparam int BIT_CRC = 3;
   localparam int BIT_PRESET = 4;
   localparam int BIT_KEEP = 6;
   localparam int BIT_SYNTAX = 7;
   localparam int BIT_DLOAD = 8;
   localparam int BIT_SYSTEM = 9;
   localparam int BIT_CLOCK = 10;
   localparam int BIT_XBUS = 11;
   localparam int BIT_CARD = 12;
   localparam int BIT_EXEC = 13;
   localparam int BIT_ACCESS = 14;
   localparam int BIT_CLEAR = 15;

   // Control register bit positions
   localparam int CTRL_KEEP_STOP = 0;
   localparam int CTRL_HOST_CLEAR = 1;

   // Fault classes that stop execution unconditionally
   localparam logic [15:0] STOP_MASK = 16'h038F;
   // Fault classes that force outputs off; the retained-data bit only when configured to stop
   localparam logic [15:0] OFF_MASK = 16'h03CF;
   // Fault classes that light the fault lamp
   localparam logic [15:0] LAMP_MASK = 16'h7F9E;

   // Reset values
   localparam logic [15:0] GFW_RESET = 16'h0000;
   localparam logic [15:0] ECW_RESET = 16'h0000;
   localparam logic CTRL_KEEP_STOP_RESET = 1'b0;

   // Fault detection events from the controller, one-cycle pulses
   typedef struct packed {
      logic scan_start;
      logic scan_end;
      logic link_init;
      logic link_err;
      logic crc_err;
      logic preset_err;
      logic keep_err;
      logic syntax_err;
      logic syntax_ok;
      logic dl_write_fail;
      logic dl_write_ok;
      logic rom_missing;
      logic clock_lost;
      logic xbus_err;
      logic card_dl_fail;
      logic card_ul_fail;
      logic exec_err;
      logic [15:0] exec_code;
      logic card_access_fail;
      logic prog_clear;
   } cfsu_evt_t;

   // Effects driven back into the controller
   typedef struct packed {
      logic run;
      logic outputs_off;
      logic fault_lamp;
      logic exec_fault_flag;
      logic preset_reload;
      logic retain_clear;
   } cfsu_ctl_t;

endpackage : cfsu_pkg

// File: verilog/cfsu_scan_watchdog.sv
// Purpose: Measures each program scan and flags one overrun per scan
// Assumes: Scan start pulses come from logic on the same clock
// Notes: Counter saturates after an overrun until the next scan start
`timescale 1ns/10ps
module cfsu_scan_watchdog #(
   parameter int LIMIT = 2_000_000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scan_start_i,
   input wire logic run_i,
   output logic timeout_o
);

   // Refuse limits the counter cannot serve
   if (LIMIT < 2) begin : g_bad_limit
      $error("Scan watchdog limit must be at least two cycles");
   end

   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);

   logic [CW-1:0] count;
   logic fired;

   // Scan time counter, restarted each scan
   always_ff @(posedge clk_i) begin
      if (rst_i || scan_start_i || !run_i) begin
         count <= '0;
      end else if (count != LIM) begin
         count <= count + CW'(1);
      end
   end

   // One overrun report per scan
   always_ff @(posedge clk_i) begin
      if (rst_i || scan_start_i || !run_i) begin
         fired <= 1'b0;
         timeout_o <= 1'b0;
      end else begin
         timeout_o <= (count == LIM) && !fired;
         if (count == LIM) begin
            fired <= 1'b1;
         end
      end
   end

endmodule : cfsu_scan_watchdog

// File: verilog/cfsu_top.sv
// Purpose: Collects controller faults, decides run/output/lamp effects
// Assumes: Event pulses are on clk_i; supply and power-off pins are async
// Notes: Registers are reached over a classic Wishbone slave
// Notes: Each fault class is one bit with its own set and clear terms
// Notes: A detection in the same cycle as any clear always wins
// Notes: Host clear and served program clear wipe the whole word
// Notes: Program clear waits for the end-of-scan pulse
// Notes: Upper bit reads high while a program clear is pending
// Notes: Retained-data stop option lives in the control register
// Notes: Power bit is set again every cycle while a pin is active
// Notes: Card fault stops only when the last one was a download
// What this block does
// - General fault word, one bit per class
// - Program upper-bit write clears at scan end
// - Supply low or power off sets 0001h
// - Scan watchdog overrun sets 0002h, lamp
// - Link init fault sets 0004h, stops
// - Program checksum fault sets 0008h, lamp
// - Preset corruption sets 0010h, reloads presets
// - Retained-data fault sets 0040h, clears retained
// - Retained fault runs unless configured to stop
// - Syntax fault 0080h, auto-clears on good program
// - Storage write fault 0100h, clears on success
// - Missing program storage sets 0200h, stops
// - Clock data loss sets 0400h, keeps running
// - Module link fault sets 0800h, keeps running
// - Card transfer fault 1000h, download stops
// - Execution fault 2000h plus relay flag
// - Card write fault sets 4000h, lamp
// - Lamp follows lamp classes; status readable
// - Host clear request zeroes fault word
// - Two fault registers: general and detail
// - Execution fault stores numeric detail code
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module cfsu_top
   import cfsu_pkg::*;
#(
   parameter int WDT_LIMIT = WDT_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Asynchronous supply monitor pins
   input wire logic supply_low_i,
   input wire logic power_off_i,
   // Fault detection events from the controller
   input wire cfsu_evt_t evt_i,
   // Effects on the controller
   output cfsu_ctl_t ctl_o
);

   // Supply pin synchronisers
   logic [1:0] low_meta;
   logic [1:0] low_sync;
   logic [15:0] gfw;
   logic [15:0] next_gfw;
   logic [15:0] ecw;
   logic [15:0] set_vec;
   logic [15:0] auto_clr;
   logic keep_stop_cfg;
   logic card_dl_latched;
   logic exec_flag;
   logic wdt_timeout;
   logic run_now;
   logic stop_now;
   logic off_now;
   logic lamp_now;
   logic wb_req;
   logic wb_wr;
   logic host_clear;
   logic prog_clear_pend;
   logic prog_clear_set;
   logic clear_all;
   logic [31:0] rd_mux;

   // Two-flop synchronisers for supply and power-off pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_meta <= 2'h0;
         low_sync <= 2'h0;
      end else begin
         low_meta <= {power_off_i, supply_low_i};
         low_sync <= low_meta;
      end
   end

   // Scan time watchdog
   cfsu_scan_watchdog #(
      .LIMIT(WDT_LIMIT)
   ) u_wdt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scan_start_i(evt_i.scan_start),
      .run_i(run_now),
      .timeout_o(wdt_timeout)
   );

   // Bus request decode
   assign wb_req = cyc_i && stb_i && !ack_o;
   assign wb_wr = wb_req && we_i;
   assign host_clear = wb_wr && (adr_i == OFS_CTRL) && sel_i[0] && dat_i[CTRL_HOST_CLEAR];
   assign prog_clear_set = evt_i.prog_clear
      || (wb_wr && (adr_i == OFS_GFW) && sel_i[1] && dat_i[BIT_CLEAR]);

   // Fault detections, one bit per class
   always_comb begin
      set_vec = 16'h0000;
      set_vec[BIT_POWER] = |low_sync;
      set_vec[BIT_WDT] = wdt_timeout;
      set_vec[BIT_LINK] = evt_i.link_err;
      set_vec[BIT_CRC] = evt_i.crc_err;
      set_vec[BIT_PRESET] = evt_i.preset_err;
      set_vec[BIT_KEEP] = evt_i.keep_err;
      set_vec[BIT_SYNTAX] = evt_i.syntax_err;
      set_vec[BIT_DLOAD] = evt_i.dl_write_fail;
      set_vec[BIT_SYSTEM] = evt_i.rom_missing;
      set_vec[BIT_CLOCK] = evt_i.clock_lost;
      set_vec[BIT_XBUS] = evt_i.xbus_err;
      set_vec[BIT_CARD] = evt_i.card_dl_fail || evt_i.card_ul_fail;
      set_vec[BIT_EXEC] = evt_i.exec_err;
      set_vec[BIT_ACCESS] = evt_i.card_access_fail;
   end

   // Self-clearing classes on a successful retry
   always_comb begin
      auto_clr = 16'h0000;
      auto_clr[BIT_SYNTAX] = evt_i.syntax_ok;
      auto_clr[BIT_DLOAD] = evt_i.dl_write_ok;
      auto_clr[BIT_LINK] = evt_i.link_init;
   end

   // Whole-word clear from the host or a served program clear
   assign clear_all = host_clear || (evt_i.scan_end && prog_clear_pend);

   // One fault class per bit; a detection wins over any clear
   for (genvar b = 0; b < 16; b++) begin : g_bit
      // Next value of this class
      always_comb begin
         if (set_vec[b]) begin
            next_gfw[b] = 1'b1;
         end else if (clear_all || auto_clr[b]) begin
            next_gfw[b] = 1'b0;
         end else if (b == BIT_CLEAR) begin
            next_gfw[b] = 1'b0;
         end else begin
            next_gfw[b] = gfw[b];
         end
      end

      // Storage of this class
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            gfw[b] <= GFW_RESET[b];
         end else begin
            gfw[b] <= next_gfw[b];
         end
      end
   end

   // Pending program clear, served at end of scan
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prog_clear_pend <= 1'b0;
      end else if (prog_clear_set) begin
         prog_clear_pend <= 1'b1;
      end else if (evt_i.scan_end || host_clear) begin
         prog_clear_pend <= 1'b0;
      end
   end

   // Execution fault detail code and relay flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ecw <= ECW_RESET;
         exec_flag <= 1'b0;
      end else if (evt_i.exec_err) begin
         ecw <= evt_i.exec_code;
         exec_flag <= 1'b1;
      end else if (clear_all) begin
         ecw <= ECW_RESET;
         exec_flag <= 1'b0;
      end
   end

   // Remembers whether the card fault came from a download
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         card_dl_latched <= 1'b0;
      end else if (evt_i.card_dl_fail) begin
         card_dl_latched <= 1'b1;
      end else if (evt_i.card_ul_fail || !gfw[BIT_CARD]) begin
         card_dl_latched <= 1'b0;
      end
   end

   // Retained-data stop option
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         keep_stop_cfg <= CTRL_KEEP_STOP_RESET;
      end else if (wb_wr && (adr_i == OFS_CTRL) && sel_i[0]) begin
         keep_stop_cfg <= dat_i[CTRL_KEEP_STOP];
      end
   end

   // Stop, output and lamp decisions from present faults
   always_comb begin
      stop_now = |(gfw & STOP_MASK);
      off_now = |(gfw & OFF_MASK);
      if (gfw[BIT_KEEP] && keep_stop_cfg) begin
         stop_now = 1'b1;
      end
      if (gfw[BIT_KEEP] && !keep_stop_cfg) begin
         off_now = |(gfw & OFF_MASK & ~(16'h0001 << BIT_KEEP));
      end
      if (gfw[BIT_CARD] && card_dl_latched) begin
         stop_now = 1'b1;
         off_now = 1'b1;
      end
      if (gfw[BIT_DLOAD]) begin
         off_now = 1'b1;
      end
      lamp_now = |(gfw & LAMP_MASK);
      run_now = !stop_now;
   end

   // Registered effects toward the controller
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_o <= '0;
      end else begin
         ctl_o.run <= run_now;
         ctl_o.outputs_off <= off_now || stop_now;
         ctl_o.fault_lamp <= lamp_now;
         ctl_o.exec_fault_flag <= exec_flag;
         ctl_o.preset_reload <= evt_i.preset_err;
         ctl_o.retain_clear <= evt_i.keep_err;
      end
   end

   // Read data selection; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (adr_i)
         OFS_GFW: rd_mux = {16'h0000, gfw[15] | prog_clear_pend, gfw[14:0]};
         OFS_ECW: rd_mux = {16'h0000, ecw};
         OFS_CTRL: rd_mux = {31'h0000_0000, keep_stop_cfg};
         OFS_STAT: rd_mux = {26'h000_0000, exec_flag, card_dl_latched,
                             lamp_now, off_now || stop_now, stop_now, run_now};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Single-wait acknowledge and registered read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= wb_req;
         if (wb_req && !we_i) begin
            dat_o <= rd_mux;
         end
      end
   end

endmodule : cfsu_top

// File: tb/cfsu_top_properties.sv
// Purpose: Port-level checks of the fault status unit
// Assumes: One clock, synchronous active-high reset
// Notes: Bound onto cfsu_top below the module
`timescale 1ns/10ps
module cfsu_top_props
   import cfsu_pkg::*;
#(
   parameter int WDT_LIMIT = WDT_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic supply_low_i,
   input wire cfsu_evt_t evt_i,
   input wire cfsu_ctl_t ctl_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answer timing
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked next cycle");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   // Fault effects two cycles after the event
   a_crc_stop: assert property (evt_i.crc_err |-> ##2 !ctl_o.run && ctl_o.outputs_off)
      else $error("checksum fault did not stop");
   a_rom_stop: assert property (evt_i.rom_missing |-> ##2 !ctl_o.run && ctl_o.fault_lamp)
      else $error("missing storage did not stop");
   a_exec_flag: assert property (evt_i.exec_err |-> ##2 ctl_o.exec_fault_flag)
      else $error("execution flag not raised");
   a_clock_lamp: assert property (evt_i.clock_lost |-> ##2 ctl_o.fault_lamp)
      else $error("clock loss lamp not lit");
   // Side-effect pulses
   a_preset_reload: assert property (evt_i.preset_err |=> ctl_o.preset_reload)
      else $error("preset reload missing");
   a_retain_clear: assert property (evt_i.keep_err |=> ctl_o.retain_clear)
      else $error("retained clear missing");
   // Supply pin through synchroniser
   a_power_stop: assert property (supply_low_i ##1 supply_low_i |-> ##3 !ctl_o.run)
      else $error("supply low did not stop");
endmodule : cfsu_top_props
bind cfsu_top cfsu_top_props #(.WDT_LIMIT(WDT_LIMIT)) props_u (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .supply_low_i(supply_low_i),
   .evt_i(evt_i), .ctl_o(ctl_o));

// File: tb/cfsu_host_model.sv
// Purpose: Host tool model reaching the fault registers
// Assumes: Classic Wishbone single cycles, one at a time
// Notes: No fixed latency assumed; bench watchdog ends hangs
`timescale 1ns/10ps
module cfsu_host_model
   import cfsu_pkg::*;
(
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   // Idle bus at time zero
   initial begin
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   end
   // One cycle, held until the rising edge that samples ack high
   task automatic xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      {cyc_o, stb_o} <= 2'b00;
   endtask : xfer
   // Host clear request through the control register
   task automatic clr;
      logic [31:0] q;
      xfer(1'b1, OFS_CTRL, 4'h1, 32'h0000_0002, q);
   endtask : clr
endmodule : cfsu_host_model

// File: tb/test_controller_fault_status_unit.sv
// Purpose: Self-checking bench of the fault status unit
// Assumes: Host model drives the register bus
// Notes: Short watchdog limit keeps the run brief
`timescale 1ns/10ps
module test_controller_fault_status_unit
   import cfsu_pkg::*;
;
   localparam int LIM = 20;
   localparam logic [18:0] EXP [13] = '{{16'h0004, 3'b011}, {16'h0008, 3'b011},
      {16'h0010, 3'b101}, {16'h0040, 3'b100}, {16'h0080, 3'b011}, {16'h0100, 3'b011},
      {16'h0200, 3'b011}, {16'h0400, 3'b101}, {16'h0800, 3'b101}, {16'h1000, 3'b011},
      {16'h1000, 3'b101}, {16'h2000, 3'b101}, {16'h4000, 3'b101}};
   logic clk_i = 1'b0, rst_i = 1'b1, supply_low_i = 1'b0, power_off_i = 1'b0, kick = 1'b1;
   logic cyc, stb, we, ack;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat, got;
   logic [2:0] tick = '0;
   cfsu_evt_t evt_s = '0, evt_w, e;
   cfsu_ctl_t ctl;
   int errors = 0, compares = 0;
   // Clock and periodic scan start
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) tick <= tick + 3'h1;
   always_comb begin
      evt_w = evt_s;
      evt_w.scan_start = kick && (tick == 3'h0);
   end
   cfsu_top #(.WDT_LIMIT(LIM)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .supply_low_i(supply_low_i), .power_off_i(power_off_i), .evt_i(evt_w), .ctl_o(ctl));
   cfsu_host_model host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk
   task automatic rdc(input logic [3:0] a, input logic [31:0] x);
      host_u.xfer(1'b0, a, 4'hF, 32'h0, got);
      chk(got, x);
   endtask : rdc
   task automatic chk_ctl(input logic [2:0] x);
      chk({29'h0, ctl.run, ctl.outputs_off, ctl.fault_lamp}, {29'h0, x});
   endtask : chk_ctl
   // One-cycle event pulse, then settle
   task automatic ev(input cfsu_evt_t p);
      @(posedge clk_i);
      evt_s <= p;
      @(posedge clk_i);
      evt_s <= '0;
      repeat (3) @(posedge clk_i);
   endtask : ev
   function automatic cfsu_evt_t mk(input int i);
      mk = '0;
      case (i)
         0: mk.link_err = 1'b1;
         1: mk.crc_err = 1'b1;
         2: mk.preset_err = 1'b1;
         3: mk.keep_err = 1'b1;
         4: mk.syntax_err = 1'b1;
         5: mk.dl_write_fail = 1'b1;
         6: mk.rom_missing = 1'b1;
         7: mk.clock_lost = 1'b1;
         8: mk.xbus_err = 1'b1;
         9: mk.card_dl_fail = 1'b1;
         10: mk.card_ul_fail = 1'b1;
         11: mk.exec_err = 1'b1;
         12: mk.card_access_fail = 1'b1;
         13: mk.link_init = 1'b1;
         14: mk.syntax_ok = 1'b1;
         default: mk.dl_write_ok = 1'b1;
      endcase
   endfunction : mk
   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(OFS_GFW, 32'h0);
      rdc(OFS_ECW, 32'h0);
      rdc(4'h1, 32'h0);
      rdc(OFS_STAT, 32'h1);
      rdc(OFS_CTRL, 32'h0);
      chk_ctl(3'b100);
      // Each event-driven fault class, then its own clear path
      for (int i = 0; i < 13; i++) begin
         int c;
         c = (i == 0) ? 13 : (i == 4) ? 14 : (i == 5) ? 15 : 0;
         ev(mk(i));
         rdc(OFS_GFW, {16'h0, EXP[i][18:3]});
         chk_ctl(EXP[i][2:0]);
         if (c != 0) ev(mk(c));
         else host_u.clr();
         rdc(OFS_GFW, 32'h0);
      end
      host_u.xfer(1'b1, OFS_CTRL, 4'h1, 32'h1, got);
      rdc(OFS_CTRL, 32'h1);
      ev(mk(3));
      chk_ctl(3'b010);
      rdc(OFS_STAT, 32'h6);
      host_u.xfer(1'b1, OFS_CTRL, 4'h1, 32'h2, got);
      // Detail code, then program clear at scan end
      e = mk(11);
      e.exec_code = 16'h0001;
      ev(e);
      rdc(OFS_ECW, 32'h1);
      chk({31'h0, ctl.exec_fault_flag}, 32'h1);
      e = '0;
      e.prog_clear = 1'b1;
      ev(e);
      rdc(OFS_GFW, 32'hA000);
      e = '0;
      e.scan_end = 1'b1;
      ev(e);
      rdc(OFS_GFW, 32'h0);
      rdc(OFS_ECW, 32'h0);
      host_u.xfer(1'b1, OFS_GFW, 4'h2, 32'h8000, got);
      rdc(OFS_GFW, 32'h8000);
      host_u.clr();
      rdc(OFS_GFW, 32'h0);
      // Supply pins; clear while the cause persists
      supply_low_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rdc(OFS_GFW, 32'h1);
      chk_ctl(3'b010);
      supply_low_i <= 1'b0;
      power_off_i <= 1'b1;
      host_u.clr();
      repeat (4) @(posedge clk_i);
      rdc(OFS_GFW, 32'h1);
      power_off_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      host_u.clr();
      rdc(OFS_GFW, 32'h0);
      // Scan overrun
      kick <= 1'b0;
      repeat (LIM + 12) @(posedge clk_i);
      rdc(OFS_GFW, 32'h2);
      chk_ctl(3'b011);
      kick <= 1'b1;
      host_u.clr();
      rdc(OFS_GFW, 32'h0);
      wrap_up();
   end
endmodule : test_controller_fault_status_unit
